// file: rtl/beh_map.svh
// constants for the bus exception handler
`ifndef BEH_MAP_SVH
`define BEH_MAP_SVH
`define BEH_SAS_W        4
`define BEH_SAS_IFETCH   4'h8
`define BEH_SAS_IFETCH_D 4'hC
`define BEH_SAS_PREFETCH 4'h9
`define BEH_TRANSFER_SIZE_W      2
`define BEH_TRANSFER_SIZE_DBL    2'h3
`define BEH_TRANSFER_SIZE_WORD   2'h0
`define BEH_DATA_LATCHED_STROBE_N_STATE   3'h5
`define BEH_IDLE_STATES  2'h2
`define BEH_STATE_W      3
`endif

// file: rtl/beh_pkg.sv
// types for the bus exception handler
package beh_pkg;
  typedef enum logic [7:0] {
    BEH_IDLE    = 8'h01,
    BEH_ACCESS  = 8'h02,
    BEH_SYNCWIN = 8'h04,
    BEH_XIDLE   = 8'h08,
    BEH_FLOAT   = 8'h10,
    BEH_GRANT   = 8'h20,
    BEH_WAITRTY = 8'h40,
    BEH_DONE    = 8'h80
  } beh_state_type;
  typedef enum logic [1:0] {
    BEH_END_OK    = 2'h0,
    BEH_END_FAULT = 2'h1,
    BEH_END_RETRY = 2'h2,
    BEH_END_RELQ  = 2'h3
  } beh_end_type;
endpackage

// file: rtl/beh_exception_unit.sv
// bus exception sequencer of the processor bus interface
`include "beh_map.svh"

// Functional notes
// (RQ1) relinquish beats retry and fault; release bus, grant, retry later
// (RQ2) after relinquish with fault, fault honoured only if present on retry
// (RQ3) relinquish with retry: float, grant, rerun after both negated
// (RQ4) retry beats fault; fault counts only if still present on rerun
// (RQ5) priority handling only while this processor masters the bus
// (RQ6) no ack: wait states, fault sampled each wait state ends access
// (RQ7) faulted access enters handler; faulted prefetch silently dropped
// (RQ8) sampled fault suppresses data-latched strobe from state five on
// (RQ9) sync ready with fault: synchronous fault, end, no latched strobe
// (RQ10) after async ack, fault sampled in next state ends access
// (RQ11) retry sampled like fault; rerun identical access after removal
// (RQ12) relinquish: end, float after second idle, grant one cycle later
// (RQ13) requester holds relinquish while on bus; rerun on removal
// (RQ14) relinquished: address, data, strobes, size, direction, status float
// (RQ15) burst-fetch accept sampled only with ack, ready or exception
// (RQ16) fault first burst word on fetch: strobe drop, address strobe held
// (RQ17) fault first burst word on prefetch: discard, finish second word; code drops it and ends the access, no second word
// (RQ18) retry first burst word: drop strobes, await removal, rerun burst
// (RQ19) retry second burst word: internal prefetch fault, no rerun
// (RQ20) relinquish first burst word: float, grant, rerun burst on removal
// (RQ21) relinquish second burst word: float, grant, next access, no rerun
// (RQ22) external exception inputs held until access visibly terminated
module beh_exception_unit (
  // clock and reset
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_sys_rst,
  // access request from the core
  input  wire logic                    i_start,
  input  wire logic [31:0]             i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic [`BEH_SAS_W-1:0]   i_access_status_code,
  input  wire logic [`BEH_TRANSFER_SIZE_W-1:0] i_transfer_size,
  input  wire logic                    i_read_not_write,
  input  wire logic                    i_bus_master,
  // external bus inputs
  input  wire logic                    i_async_ack_n,
  input  wire logic                    i_sync_ready_n,
  input  wire logic                    i_fault_n,
  input  wire logic                    i_retry_n,
  input  wire logic                    i_relinquish_request_n,
  input  wire logic                    i_burst_fetch_accept_n,
  // bus drives
  output logic [31:0]                  o_addr,
  output logic [31:0]                  o_data,
  output logic                         o_bus_oe,
  output logic                         o_address_strobe_n,
  output logic                         o_data_strobe_n,
  output logic                         o_data_latched_strobe_n,
  output logic                         o_cycle_initiate_n,
  output logic [`BEH_TRANSFER_SIZE_W-1:0]      o_transfer_size,
  output logic                         o_read_not_write,
  output logic [`BEH_SAS_W-1:0]        o_access_status_code,
  output logic                         o_relinquish_grant_n,
  // results to the core
  output logic                         o_busy,
  output logic                         o_done,
  output logic                         o_fault_trap,
  output logic                         o_prefetch_drop
);

  beh_pkg::beh_state_type   st_q;
  logic [`BEH_STATE_W-1:0]  clk_state_q;
  logic [1:0]               xcnt_q;
  logic                     word2_q;
  logic                     burst_q;
  logic                     was_retry_q;
  logic                     rerun_last_q;
  logic                     next_on_release_q;
  logic                     ack_seen_q;
  logic [31:0]              addr_q;
  logic [31:0]              wdata_q;
  logic [`BEH_SAS_W-1:0]    sas_q;
  logic [`BEH_TRANSFER_SIZE_W-1:0]  size_q;
  logic                     rnw_q;
  beh_pkg::beh_end_type     end_q;

  // decoded sample points; inputs taken as synchronous
  logic fault_s;
  logic retry_s;
  logic relq_s;
  logic ack_s;
  logic rdy_s;
  logic any_exc;
  logic is_fetch;
  assign fault_s  = !i_fault_n;
  assign retry_s  = !i_retry_n;
  assign relq_s   = !i_relinquish_request_n;
  assign ack_s    = !i_async_ack_n;
  assign rdy_s    = !i_sync_ready_n;
  // (RQ5) priority only as master
  assign any_exc  = i_bus_master && (fault_s || retry_s || relq_s);
  assign is_fetch = (sas_q == `BEH_SAS_IFETCH) ||
                    (sas_q == `BEH_SAS_IFETCH_D);

  // main sequencer
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q        <= beh_pkg::BEH_IDLE;
      clk_state_q <= 3'h0;
      xcnt_q      <= 2'h0;
      word2_q     <= 1'b0;
      burst_q     <= 1'b0;
      was_retry_q <= 1'b0;
      next_on_release_q <= 1'b0;
      ack_seen_q  <= 1'b0;
      end_q       <= beh_pkg::BEH_END_OK;
    end else begin
      unique case (st_q)
        beh_pkg::BEH_IDLE: begin
          clk_state_q <= 3'h1;
          word2_q     <= 1'b0;
          ack_seen_q  <= 1'b0;
          if (i_start) begin
            st_q    <= beh_pkg::BEH_ACCESS;
            burst_q <= (i_transfer_size == `BEH_TRANSFER_SIZE_DBL);
            was_retry_q <= 1'b0;
          end
        end
        beh_pkg::BEH_ACCESS: begin
          if (clk_state_q != 3'h7) clk_state_q <= clk_state_q + 3'h1;
          // (RQ1) relinquish served first, then retry, then fault
          if (any_exc && relq_s) begin
            end_q  <= beh_pkg::BEH_END_RELQ;
            st_q   <= beh_pkg::BEH_XIDLE;
            xcnt_q <= 2'h0;
            // (RQ21) second burst word: no rerun after release
            next_on_release_q <= word2_q;
          end else if (any_exc && retry_s) begin
            // (RQ4) retry beats fault
            end_q  <= beh_pkg::BEH_END_RETRY;
            st_q   <= beh_pkg::BEH_XIDLE;
            xcnt_q <= 2'h0;
          end else if (any_exc && fault_s) begin
            // (RQ6) fault in a wait state ends access; (RQ9) with ready
            end_q  <= beh_pkg::BEH_END_FAULT;
            st_q   <= beh_pkg::BEH_XIDLE;
            xcnt_q <= 2'h0;
          end else if (rdy_s || ack_seen_q) begin
            // (RQ15) burst accept only with ack or ready
            if (burst_q && !word2_q && !i_burst_fetch_accept_n) begin
              word2_q <= 1'b1;
              ack_seen_q <= 1'b0;
            end else begin
              end_q <= beh_pkg::BEH_END_OK;
              st_q  <= beh_pkg::BEH_DONE;
            end
          end else if (ack_s) begin
            // (RQ10) async ack: fault checked in following state
            ack_seen_q <= 1'b1;
          end
        end
        beh_pkg::BEH_XIDLE: begin
          // (RQ12) float only after the second idle state
          xcnt_q <= xcnt_q + 2'h1;
          if (xcnt_q == `BEH_IDLE_STATES - 2'h1) begin
            if (end_q == beh_pkg::BEH_END_RELQ)
              st_q <= beh_pkg::BEH_FLOAT;
            else if (end_q == beh_pkg::BEH_END_RETRY)
              st_q <= beh_pkg::BEH_WAITRTY;
            else
              st_q <= beh_pkg::BEH_DONE;
          end
        end
        beh_pkg::BEH_FLOAT: begin
          // (RQ12) grant one cycle after float
          st_q <= beh_pkg::BEH_GRANT;
        end
        beh_pkg::BEH_GRANT: begin
          // (RQ3) rerun only after request and retry negated
          if (!relq_s && !retry_s) begin
            if (next_on_release_q) begin
              st_q <= beh_pkg::BEH_DONE;
            end else begin
              // (RQ13) reclaim bus, rerun whole access
              st_q        <= beh_pkg::BEH_ACCESS;
              clk_state_q <= 3'h1;
              word2_q     <= 1'b0;
              ack_seen_q  <= 1'b0;
              was_retry_q <= 1'b1;
            end
          end
        end
        beh_pkg::BEH_WAITRTY: begin
          // (RQ11) keep sampling retry until removed
          if (!retry_s) begin
            if (word2_q) begin
              // (RQ19) second word: internal prefetch fault
              st_q <= beh_pkg::BEH_DONE;
            end else begin
              // (RQ18) rerun the whole burst
              st_q        <= beh_pkg::BEH_ACCESS;
              clk_state_q <= 3'h1;
              ack_seen_q  <= 1'b0;
              was_retry_q <= 1'b1;
            end
          end
        end
        beh_pkg::BEH_DONE: begin
          st_q <= beh_pkg::BEH_IDLE;
        end
        default: st_q <= beh_pkg::BEH_IDLE;
      endcase
    end
  end

  // (RQ2) fault counts only on the rerun itself, via fresh sampling
  // remembers whether the access just finished was a rerun
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rerun_last_q <= 1'b0;
    end else if (st_q == beh_pkg::BEH_DONE) begin
      rerun_last_q <= was_retry_q;
    end
  end

  // access attributes held for identical reruns
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_q  <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      sas_q   <= 4'h0;
      size_q  <= 2'h0;
      rnw_q   <= 1'b1;
    end else if (st_q == beh_pkg::BEH_IDLE && i_start) begin
      // (RQ11) same status, address, size and direction
      addr_q  <= i_addr;
      wdata_q <= i_wdata;
      sas_q   <= i_access_status_code;
      size_q  <= i_transfer_size;
      rnw_q   <= i_read_not_write;
    end
  end

  // bus pin drives
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_addr                  <= 32'h0000_0000;
      o_data                  <= 32'h0000_0000;
      o_bus_oe                <= 1'b0;
      o_address_strobe_n      <= 1'b1;
      o_data_strobe_n         <= 1'b1;
      o_data_latched_strobe_n <= 1'b1;
      o_cycle_initiate_n      <= 1'b1;
      o_transfer_size         <= 2'h0;
      o_read_not_write        <= 1'b1;
      o_access_status_code    <= 4'h0;
      o_relinquish_grant_n    <= 1'b1;
    end else begin
      // (RQ14) float all bus outputs while relinquished
      o_bus_oe <= i_bus_master && st_q != beh_pkg::BEH_FLOAT &&
                  st_q != beh_pkg::BEH_GRANT;
      o_addr   <= addr_q;
      o_data   <= wdata_q;
      o_transfer_size <= word2_q ? `BEH_TRANSFER_SIZE_WORD : size_q;
      o_read_not_write <= rnw_q;
      o_access_status_code <= word2_q ? `BEH_SAS_PREFETCH : sas_q;
      o_cycle_initiate_n <= !(st_q == beh_pkg::BEH_ACCESS &&
                              clk_state_q == 3'h1 && !word2_q);
      // (RQ16) burst fetch fault holds address strobe through first idle
      o_address_strobe_n <= !(st_q == beh_pkg::BEH_ACCESS ||
        (st_q == beh_pkg::BEH_XIDLE && xcnt_q == 2'h0 &&
         (end_q != beh_pkg::BEH_END_FAULT || (burst_q && is_fetch))));
      // (RQ18) data strobe dropped on any exception end
      o_data_strobe_n <= (st_q != beh_pkg::BEH_ACCESS) || any_exc;
      // (RQ8) no latched strobe once any exception is sampled
      o_data_latched_strobe_n <= !(st_q == beh_pkg::BEH_ACCESS &&
        !any_exc && (rdy_s || ack_seen_q) &&
        clk_state_q < `BEH_DATA_LATCHED_STROBE_N_STATE + 3'h2);
      // (RQ20) grant one cycle after the bus floats
      o_relinquish_grant_n <= (st_q != beh_pkg::BEH_GRANT);
    end
  end

  // completion report to the core
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_busy          <= 1'b0;
      o_done          <= 1'b0;
      o_fault_trap    <= 1'b0;
      o_prefetch_drop <= 1'b0;
    end else begin
      o_busy <= (st_q != beh_pkg::BEH_IDLE);
      o_done <= (st_q == beh_pkg::BEH_DONE);
      // (RQ7) prefetch faults are dropped; (RQ17) first word prefetch too
      o_fault_trap <= st_q == beh_pkg::BEH_DONE &&
        end_q == beh_pkg::BEH_END_FAULT &&
        sas_q != `BEH_SAS_PREFETCH && !word2_q;
      o_prefetch_drop <= st_q == beh_pkg::BEH_DONE &&
        ((end_q == beh_pkg::BEH_END_FAULT &&
          (sas_q == `BEH_SAS_PREFETCH || word2_q)) ||
         (end_q == beh_pkg::BEH_END_RETRY && word2_q));
    end
  end

endmodule

// file: sim/beh_monitor.sv
// port checker for the bus exception sequencer
module beh_monitor (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // watched inputs
  input wire logic i_bus_master,
  input wire logic i_fault_n,
  input wire logic i_retry_n,
  input wire logic i_relinquish_request_n,
  // watched outputs
  input wire logic o_bus_oe,
  input wire logic o_data_latched_strobe_n,
  input wire logic o_read_not_write,
  input wire logic o_relinquish_grant_n,
  input wire logic o_busy,
  input wire logic o_fault_trap,
  input wire logic o_prefetch_drop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] fault_age_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // cycles since fault was last low, saturating
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) fault_age_q <= 4'hF;
    else if (!i_fault_n) fault_age_q <= 4'h0;
    else if (fault_age_q != 4'hF) fault_age_q <= fault_age_q + 4'h1;
  end
  a_trap_needs_fault: assert property (
    o_fault_trap |-> fault_age_q < 4'h8) else $error("trap without fault");
  a_trap_drop_apart: assert property (
    !(o_fault_trap && o_prefetch_drop)) else $error("trap and drop");
  a_fault_no_latch: assert property (
    o_busy && i_bus_master && !i_fault_n |=> o_data_latched_strobe_n)
    else $error("latch strobe after fault");
  a_retry_no_latch: assert property (
    o_busy && i_bus_master && !i_retry_n |=> o_data_latched_strobe_n)
    else $error("latch strobe after retry");
  a_relq_floats_bus: assert property (
    o_busy && i_bus_master && !i_relinquish_request_n && o_bus_oe
    |-> ##[1:8] !o_bus_oe) else $error("bus not floated");
  a_grant_after_float: assert property (
    $fell(o_relinquish_grant_n) |-> !$past(o_bus_oe) && $past(o_bus_oe, 2))
    else $error("grant not one cycle after float");
  a_grant_held_on: assert property (
    !o_relinquish_grant_n && (!i_relinquish_request_n || !i_retry_n)
    |=> !o_relinquish_grant_n) else $error("grant dropped early");
  a_grant_floats_bus: assert property (
    !o_relinquish_grant_n |-> !o_bus_oe) else $error("driving while granted");
  a_bus_reclaimed: assert property (
    $rose(o_relinquish_grant_n) |-> ##[0:8] o_bus_oe)
    else $error("bus not reclaimed");
  a_master_only: assert property (
    (!i_bus_master)[*8] |-> o_relinquish_grant_n && !o_fault_trap)
    else $error("exception served while not master");
  a_dir_steady: assert property (
    o_busy && o_bus_oe && $past(o_busy) && $past(o_bus_oe)
    |-> $stable(o_read_not_write)) else $error("direction changed");
endmodule

bind beh_exception_unit beh_monitor i_mon (
  .i_clk_sys, .i_sys_rst, .i_bus_master, .i_fault_n, .i_retry_n,
  .i_relinquish_request_n, .o_bus_oe, .o_data_latched_strobe_n,
  .o_read_not_write, .o_relinquish_grant_n, .o_busy, .o_fault_trap,
  .o_prefetch_drop);

// file: sim/beh_partner.sv
// far-side model: memory, translation unit and rival masters
module beh_partner (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // scenario choice and view of the bus
  input  wire logic [2:0] i_mode,
  input  wire logic       i_as_n,
  input  wire logic       i_oe,
  input  wire logic       i_grant_n,
  // answers, all active low
  output logic            o_ack_n,
  output logic            o_rdy_n,
  output logic            o_fault_n,
  output logic            o_retry_n,
  output logic            o_relq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mode_q;
  logic [1:0] wait_q;
  logic       ans_q;
  logic       shot_q;
  logic [2:0] rel_q;
  logic       act;
  logic       rlq;
  // a floated strobe reads high through its pull-up
  assign act = ans_q && i_oe && !i_as_n;
  assign rlq = i_mode == 3'h5 || i_mode == 3'h7;
  // two wait states, then answer; exception armed once per mode
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= 3'h0;
      wait_q <= 2'h0;
      ans_q  <= 1'b0;
      shot_q <= 1'b0;
      rel_q  <= 3'h0;
    end else begin
      mode_q <= i_mode;
      wait_q <= (!i_oe || i_as_n) ? 2'h0 : wait_q + {1'b0, wait_q != 2'h2};
      ans_q  <= i_oe && !i_as_n && wait_q == 2'h2;
      if (i_mode != mode_q) shot_q <= 1'b1;
      else if (ans_q && !act) shot_q <= 1'b0;
      if (act && shot_q) rel_q <= 3'h4;
      else if (rel_q != 3'h0 && (!rlq || !i_grant_n)) rel_q <= rel_q - 3'h1;
    end
  end
  // rerun after an exception is acknowledged plainly, except in mode five where fault stays on
  assign o_ack_n = !(act && (i_mode == 3'h0 || (!shot_q && i_mode > 3'h3)));
  assign o_rdy_n = !(act && (i_mode == 3'h1 || (i_mode == 3'h3 && shot_q)));
  // fault stays on in mode five, reruns included
  assign o_fault_n = !(act && (i_mode == 3'h5 || (shot_q &&
    (i_mode == 3'h2 || i_mode == 3'h3 || i_mode == 3'h6))));
  assign o_retry_n = !((i_mode > 3'h3 && i_mode < 3'h7) &&
    ((act && shot_q) || rel_q != 3'h0));
  assign o_relq_n = !(rlq && ((act && shot_q) || rel_q != 3'h0));
endmodule

// file: sim/testbench.sv
// self-checking bench for the bus exception sequencer
`include "beh_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    i_clk_sys, i_sys_rst, i_start, i_bus_master;
  logic                    i_read_not_write, i_burst_fetch_accept_n;
  logic [31:0]             i_addr, i_wdata, o_addr, o_data;
  logic [`BEH_SAS_W-1:0]   i_access_status_code, o_access_status_code;
  logic [`BEH_TRANSFER_SIZE_W-1:0] i_transfer_size, o_transfer_size;
  logic                    i_async_ack_n, i_sync_ready_n, i_fault_n;
  logic                    i_retry_n, i_relinquish_request_n, o_bus_oe;
  logic                    o_address_strobe_n, o_data_strobe_n, o_busy;
  logic                    o_data_latched_strobe_n, o_cycle_initiate_n;
  logic                    o_read_not_write, o_relinquish_grant_n, o_done;
  logic                    o_fault_trap, o_prefetch_drop;
  logic [2:0]              mode;
  logic [3:0]              flags;
  int                      fail_count, checks_done;
  beh_exception_unit i_dut (
    .i_clk_sys, .i_sys_rst, .i_start, .i_addr, .i_wdata,
    .i_access_status_code, .i_transfer_size, .i_read_not_write,
    .i_bus_master, .i_async_ack_n, .i_sync_ready_n, .i_fault_n,
    .i_retry_n, .i_relinquish_request_n, .i_burst_fetch_accept_n,
    .o_addr, .o_data, .o_bus_oe, .o_address_strobe_n, .o_data_strobe_n,
    .o_data_latched_strobe_n, .o_cycle_initiate_n, .o_transfer_size,
    .o_read_not_write, .o_access_status_code, .o_relinquish_grant_n,
    .o_busy, .o_done, .o_fault_trap, .o_prefetch_drop);
  beh_partner i_far (
    .i_clk_sys, .i_sys_rst, .i_mode(mode), .i_as_n(o_address_strobe_n),
    .i_oe(o_bus_oe), .i_grant_n(o_relinquish_grant_n),
    .o_ack_n(i_async_ack_n), .o_rdy_n(i_sync_ready_n),
    .o_fault_n(i_fault_n), .o_retry_n(i_retry_n),
    .o_relq_n(i_relinquish_request_n));
  // 10 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one access; flags gather done, trap, drop, grant
  task automatic access(input logic [2:0] m, input logic [3:0] access_status_code,
                        input logic rnw);
    int n;
    mode = m;
    i_access_status_code = access_status_code;
    i_read_not_write = rnw;
    i_addr = {28'h0003C00, access_status_code};
    i_wdata = ~i_addr;
    i_start = 1'b1;
    flags = 4'h0;
    @(negedge i_clk_sys);
    i_start = 1'b0;
    // bounded: a stuck access shows as busy still high
    for (n = 0; n < 200; n++) begin
      flags |= {o_done, o_fault_trap, o_prefetch_drop, !o_relinquish_grant_n};
      if (o_cycle_initiate_n === 1'b0 && o_bus_oe === 1'b1) begin
        check({o_read_not_write, o_access_status_code, o_addr},
              {rnw, access_status_code, i_addr});
      end
      // busy rises one cycle after the start pulse
      if (o_busy === 1'b0 && n > 1) break;
      @(negedge i_clk_sys);
    end
    check(o_busy, 1'b0);
    // idle mode for one cycle so the far side rearms its exception
    mode = 3'h0;
    @(negedge i_clk_sys);
  endtask
  task automatic t_burst;
    i_transfer_size = `BEH_TRANSFER_SIZE_DBL;
    i_burst_fetch_accept_n = 1'b0;
    access(3'h0, `BEH_SAS_IFETCH, 1'b1);
    check(flags, 4'b1000);
    access(3'h2, `BEH_SAS_IFETCH, 1'b1);
    check(flags[2:0], 3'b100);
    i_transfer_size = `BEH_TRANSFER_SIZE_WORD;
    i_burst_fetch_accept_n = 1'b1;
  endtask
  task automatic t_plain;
    access(3'h0, `BEH_SAS_IFETCH, 1'b1);
    check(flags, 4'b1000);
    access(3'h1, `BEH_SAS_IFETCH, 1'b0);
    check(flags, 4'b1000);
  endtask
  task automatic t_fault;
    for (int r = 0; r < 2; r++) begin
      access(3'h2, `BEH_SAS_IFETCH, r[0]);
      check(flags[2:0], 3'b100);
      access(3'h2, `BEH_SAS_PREFETCH, r[0]);
      check(flags[2:0], 3'b010);
      access(3'h3, `BEH_SAS_IFETCH_D, r[0]);
      check(flags[2:0], 3'b100);
    end
  endtask
  task automatic t_retry;
    access(3'h4, `BEH_SAS_IFETCH, 1'b1);
    check(flags, 4'b1000);
  endtask
  task automatic t_retry_fault;
    access(3'h6, `BEH_SAS_IFETCH, 1'b0);
    check(flags, 4'b1000);
  endtask
  task automatic t_relq;
    access(3'h7, `BEH_SAS_IFETCH, 1'b0);
    check(flags, 4'b1001);
  endtask
  task automatic t_relq_all;
    access(3'h5, `BEH_SAS_IFETCH, 1'b1);
    check(flags[2:0], 3'b101);
  endtask
  // fourteen accesses of at most two hundred cycles each
  initial begin
    #400000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    fail_count = 0;
    checks_done = 0;
    i_sys_rst = 1'b1;
    i_start = 1'b0;
    i_bus_master = 1'b0;
    i_burst_fetch_accept_n = 1'b1;
    i_transfer_size = `BEH_TRANSFER_SIZE_WORD;
    i_addr = 32'h0;
    i_wdata = 32'h0;
    i_access_status_code = 4'h0;
    i_read_not_write = 1'b1;
    mode = 3'h0;
    repeat (3) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    // idle spell without bus ownership first
    repeat (10) @(negedge i_clk_sys);
    i_bus_master = 1'b1;
    t_plain;
    t_fault;
    t_retry;
    t_retry_fault;
    t_relq;
    t_relq_all;
    t_burst;
    tally_and_finish;
  end
endmodule
